/* File: bench/mbmcl_slave.sv */
// partner model: framer plus slave, takes requests and returns one register pair per read
module mbmcl_slave (
	input  wire logic                  clk_in,
	input  wire logic                  req_valid_in,
	input  wire mbmcl_pkg::mbmcl_req_t req_in,
	input  wire logic [3:0]            delay_in,
	output logic                       ready_out,
	output logic                       done_out,
	output logic                       rsp_valid_out,
	output logic [31:0]                rsp_data_out,
	output mbmcl_pkg::mbmcl_req_t      last_out,
	output int                         cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// answer loop, ready, response and done change at the falling edge, last_out and cnt_out at the rising edge
	initial begin
		ready_out = 1'b0;
		done_out = 1'b0;
		rsp_valid_out = 1'b0;
		rsp_data_out = 32'hEDCBA987;
		last_out = '0;
		cnt_out = 0;
		forever begin
			@(negedge clk_in);
			if (req_valid_in) begin
				repeat (delay_in) @(negedge clk_in);
				ready_out = 1'b1;
				@(posedge clk_in);
				last_out = req_in;
				cnt_out++;
				@(negedge clk_in);
				ready_out = 1'b0;
				if (last_out.is_read) begin
					rsp_valid_out = 1'b1;
					rsp_data_out = 32'h12345678;
					@(negedge clk_in);
					rsp_valid_out = 1'b0;
					rsp_data_out = 32'hEDCBA987; // released bus shows inverse
				end
				done_out = 1'b1;
				@(negedge clk_in);
				done_out = 1'b0;
			end
		end
	end
endmodule

/* File: bench/mbmcl_top_tb.sv */
// self-checking testbench of the master command list executor
module mbmcl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0]  fc;
		logic [1:0]  sw;
		logic [7:0]  nd;
		logic [15:0] n;
		logic [1:0]  sp;
		logic        bt;
		logic [31:0] dat;
	} mbmcl_row_t;
	// ==========================================================
	// stimulus signals and design outputs
	logic clk = 1'b0, rst_n = 1'b0, ldv = 1'b0, run = 1'b0, trig = 1'b0, chg = 1'b0;
	logic [4:0] cmd_count = 5'h10;
	logic [3:0] dly = 4'h0;
	mbmcl_pkg::mbmcl_ld_kind_t ldk = mbmcl_pkg::MBMCL_LD_REC;
	mbmcl_pkg::mbmcl_cmd_t ldr = '0;
	mbmcl_pkg::mbmcl_req_t req, last;
	logic ready, done, rsv, reqv, we, loaded, busy, bad;
	logic [31:0] rsd, wd, wd_q;
	logic [15:0] wa, wa_q;
	logic [4:0] len;
	int error_cnt = 0, total_checks = 0, scnt, bad_n = 0, wcnt = 0, cyc = 0, last_iss = 0, gap_min;
	int s, w;
	// space codes: 0 coil, 1 discrete, 2 input, 3 holding
	mbmcl_row_t rows [11] = '{
		'{8'h01, 2'h2, 8'h11, 16'h0010, 2'h0, 1'b1, 32'h12345678},
		'{8'h02, 2'h0, 8'h11, 16'h0008, 2'h1, 1'b1, 32'h12345678},
		'{8'h03, 2'h0, 8'h22, 16'h0002, 2'h3, 1'b0, 32'h12345678},
		'{8'h03, 2'h1, 8'h01, 16'h0002, 2'h3, 1'b0, 32'h56781234},
		'{8'h03, 2'h2, 8'hFF, 16'h0002, 2'h3, 1'b0, 32'h78563412},
		'{8'h03, 2'h3, 8'h11, 16'h0002, 2'h3, 1'b0, 32'h34127856},
		'{8'h04, 2'h1, 8'h11, 16'h0002, 2'h2, 1'b0, 32'h12345678},
		'{8'h05, 2'h0, 8'h11, 16'h0007, 2'h0, 1'b1, 32'h0},
		'{8'h06, 2'h0, 8'h11, 16'h0009, 2'h3, 1'b0, 32'h0},
		'{8'h0F, 2'h0, 8'h00, 16'h0014, 2'h0, 1'b1, 32'h0},
		'{8'h10, 2'h0, 8'h00, 16'h0004, 2'h3, 1'b0, 32'h0}};
	mbmcl_top #(.SEC_CYCLES(20)) DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .cmd_count_in(cmd_count),
		.ld_valid_in(ldv), .ld_kind_in(ldk), .ld_rec_in(ldr), .run_in(run), .trig_in(trig),
		.trig_idx_in(4'h0), .chg_in(chg), .chg_idx_in(4'h0), .req_ready_in(ready), .done_in(done),
		.rsp_valid_in(rsv), .rsp_data_in(rsd), .req_valid_out(reqv), .req_out(req), .db_we_out(we),
		.db_addr_out(wa), .db_data_out(wd), .list_len_out(len), .list_loaded_out(loaded),
		.busy_out(busy), .bad_cmd_out(bad));
	mbmcl_slave u_slave (.clk_in(clk), .req_valid_in(reqv), .req_in(req), .delay_in(dly),
		.ready_out(ready), .done_out(done), .rsp_valid_out(rsv), .rsp_data_out(rsd),
		.last_out(last), .cnt_out(scnt));
	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// monitor: store writes, reject pulses and issue spacing
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bad === 1'b1) bad_n <= bad_n + 1;
		if (we === 1'b1) begin
			wa_q <= wa;
			wd_q <= wd;
			wcnt <= wcnt + 1;
		end
		if (reqv === 1'b1 && ready === 1'b1) begin
			if (cyc - last_iss < gap_min) gap_min <= cyc - last_iss;
			last_iss <= cyc;
		end
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ld(input mbmcl_pkg::mbmcl_ld_kind_t k, input mbmcl_pkg::mbmcl_cmd_t r);
		@(negedge clk);
		ldv = 1'b1;
		ldk = k;
		ldr = r;
		@(negedge clk);
		ldv = 1'b0;
	endtask
	function automatic mbmcl_pkg::mbmcl_cmd_t mk(input logic [2:0] en, input logic [7:0] fc,
		input logic [1:0] sw, input logic [7:0] nd, input logic [15:0] n, input logic [15:0] ps);
		mk = '{en, 16'h0200, ps, n, sw, nd, fc, 16'h0123};
	endfunction
	// load a one-entry list and let it poll for n cycles
	task automatic go(input mbmcl_pkg::mbmcl_cmd_t r, input int n);
		@(negedge clk);
		run = 1'b0;
		repeat (60) @(negedge clk);
		ld(mbmcl_pkg::MBMCL_LD_START, r);
		ld(mbmcl_pkg::MBMCL_LD_REC, r);
		ld(mbmcl_pkg::MBMCL_LD_END, r);
		run = 1'b1;
		repeat (n) @(negedge clk);
		run = 1'b0;
		repeat (40) @(negedge clk);
	endtask
	task automatic kick(input logic t);
		run = 1'b1;
		trig = t;
		chg = ~t;
		@(negedge clk);
		trig = 1'b0;
		chg = 1'b0;
		repeat (40) @(negedge clk);
		run = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk(busy, 0);
		chk(loaded, 0);
		cmd_count = 5'h02; // list stops at the port count
		ld(mbmcl_pkg::MBMCL_LD_START, '0);
		repeat (3) ld(mbmcl_pkg::MBMCL_LD_REC, '0);
		chk(len, 2);
		chk(loaded, 1);
		cmd_count = 5'h10;
		foreach (rows[i]) begin
			s = scnt;
			w = wcnt;
			dly = 4'(i % 3);
			go(mk(mbmcl_pkg::EN_POLL, rows[i].fc, rows[i].sw, rows[i].nd, rows[i].n, 16'h0), 30);
			chk(scnt > s, 1);
			chk(last.func, rows[i].fc);
			chk(last.space, rows[i].sp);
			chk(last.bits, rows[i].bt);
			chk(last.is_read, rows[i].fc < 8'h05);
			chk(last.count, (rows[i].fc inside {8'h05, 8'h06}) ? 16'h1 : rows[i].n);
			chk(last.offset, 16'h0123);
			chk(last.node, rows[i].nd);
			chk(last.bcast, rows[i].nd == 8'h00);
			chk(last.int_addr, 16'h0200);
			if (rows[i].fc < 8'h05) begin
				chk(wcnt > w, 1);
				chk(wa_q, 16'h0200);
				chk(wd_q, rows[i].dat);
			end
		end
		s = scnt;
		go(mk(mbmcl_pkg::EN_OFF, 8'h06, 2'h0, 8'h05, 16'h1, 16'h0), 40);
		chk(scnt - s, 0);
		kick(1'b1);
		chk(scnt - s, 1);
		for (int j = 0; j < 2; j++) begin
			s = scnt;
			go(mk(j ? mbmcl_pkg::EN_CHANGE_NF : mbmcl_pkg::EN_CHANGE, 8'h10, 2'h0, 8'h09, 16'h3, 16'h0), 40);
			chk(scnt - s, 0);
			kick(1'b0);
			chk(scnt - s, 1);
		end
		s = scnt;
		w = bad_n;
		go(mk(mbmcl_pkg::EN_POLL, 8'h03, 2'h0, 8'h00, 16'h2, 16'h0), 20);
		chk(bad_n > w, 1);
		w = bad_n;
		go(mk(mbmcl_pkg::EN_CHANGE, 8'h03, 2'h0, 8'h07, 16'h2, 16'h0), 20);
		kick(1'b0);
		chk(bad_n > w, 1);
		chk(scnt - s, 0);
		gap_min = 1000;
		s = scnt;
		go(mk(mbmcl_pkg::EN_POLL_NF, 8'h05, 2'h0, 8'h03, 16'h1, 16'h1), 150);
		chk(gap_min >= 20, 1);
		chk(scnt - s >= 3, 1);
		// reset after the run has stopped clears the list and the outputs
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		chk(len, 0);
		chk(loaded, 0);
		rst_n = 1'b1;
		@(negedge clk);
		chk(busy, 0);
		chk(bad, 0);
		chk(reqv, 0);
		test_done();
	end
endmodule

/* File: rtl/mbmcl_pkg.sv */
// shared constants, codes and record layouts of the master command list
package mbmcl_pkg;
	// ==========================================================
	// list geometry
	localparam int          NCMD     = 16;
	localparam int          IDXW     = 4;
	localparam int          LENW     = 5;
	// ==========================================================
	// timing: one poll second as a cycle count
	localparam longint      ONE_SEC_NS    = 1000000000;
	localparam longint      CLK_PERIOD_NS = 5;
	localparam int unsigned SEC_CYCLES    = int'(ONE_SEC_NS / CLK_PERIOD_NS);
	localparam int          SECW          = 28;
	// ==========================================================
	// function codes
	localparam logic [7:0]  FC_RD_COIL   = 8'h01;
	localparam logic [7:0]  FC_RD_DISC   = 8'h02;
	localparam logic [7:0]  FC_RD_HOLD   = 8'h03;
	localparam logic [7:0]  FC_RD_INPUT  = 8'h04;
	localparam logic [7:0]  FC_WR_COIL   = 8'h05;
	localparam logic [7:0]  FC_WR_REG    = 8'h06;
	localparam logic [7:0]  FC_WR_COILS  = 8'h0F;
	localparam logic [7:0]  FC_WR_REGS   = 8'h10;
	// enable codes
	localparam logic [2:0]  EN_OFF       = 3'h0;
	localparam logic [2:0]  EN_POLL      = 3'h1;
	localparam logic [2:0]  EN_CHANGE    = 3'h2;
	localparam logic [2:0]  EN_POLL_NF   = 3'h3;
	localparam logic [2:0]  EN_CHANGE_NF = 3'h4;
	// swap codes
	localparam logic [1:0]  SW_NONE      = 2'h0;
	localparam logic [1:0]  SW_WORDS     = 2'h1;
	localparam logic [1:0]  SW_ALL       = 2'h2;
	localparam logic [1:0]  SW_BYTES     = 2'h3;
	// broadcast station address
	localparam logic [7:0]  NODE_BCAST   = 8'h00;
	// single-point count and register pair stride
	localparam logic [15:0] ONE_POINT    = 16'h0001;
	localparam logic [15:0] PAIR_STRIDE  = 16'h0002;
	// ==========================================================
	// load stream markers
	typedef enum logic [1:0] {
		MBMCL_LD_REC   = 2'h0,
		MBMCL_LD_START = 2'h1,
		MBMCL_LD_END   = 2'h2
	} mbmcl_ld_kind_t;
	// data range addressed by a request
	typedef enum logic [1:0] {
		MBMCL_SP_COIL  = 2'h0,
		MBMCL_SP_DISC  = 2'h1,
		MBMCL_SP_INPUT = 2'h2,
		MBMCL_SP_HOLD  = 2'h3
	} mbmcl_space_t;
	// one command list record
	typedef struct packed {
		logic [2:0]  enable;
		logic [15:0] int_addr;
		logic [15:0] poll_sec;
		logic [15:0] count;
		logic [1:0]  swap;
		logic [7:0]  node;
		logic [7:0]  func;
		logic [15:0] dev_addr;
	} mbmcl_cmd_t;
	// request handed to the serial framer
	typedef struct packed {
		logic [7:0]   node;
		logic         bcast;
		logic [7:0]   func;
		mbmcl_space_t space;
		logic         bits;
		logic         is_read;
		logic [15:0]  offset;
		logic [15:0]  count;
		logic [15:0]  int_addr;
	} mbmcl_req_t;
endpackage

/* File: rtl/mbmcl_swap.sv */
// byte and word reordering of one received register pair
module mbmcl_swap (
	input  wire logic [31:0] data_in,
	input  wire logic [1:0]  code_in,
	output logic      [31:0] data_out
);
	// bytes 1234 sit in [31:24] [23:16] [15:8] [7:0]
	wire logic [31:0] words_x = {data_in[15:0], data_in[31:16]};
	wire logic [31:0] bytes_x = {data_in[23:16], data_in[31:24], data_in[7:0], data_in[15:8]};
	wire logic [31:0] all_x   = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
	// select by code
	assign data_out = (code_in == mbmcl_pkg::SW_WORDS) ? words_x :   // RULE11
	                  (code_in == mbmcl_pkg::SW_ALL)   ? all_x   :   // RULE11
	                  (code_in == mbmcl_pkg::SW_BYTES) ? bytes_x :   // RULE11
	                  data_in;
endmodule

/* File: rtl/mbmcl_top.sv */
// master command list executor: list load, poll scheduling, request build, read data store
// What this block does
// RULE1 - records are taken after the start marker until the end marker or the port command count, whichever first.
// RULE2 - enable code zero is skipped in polling but still runs on a host trigger.
// RULE3 - enable code one runs every pass with zero interval, otherwise whenever its interval timer has run out.
// RULE4 - enable code two runs only after its internal data changed, and only for write functions; a host trigger here runs it, read or write, without a change.
// RULE5 - codes three and four act as one and two with float handling suppressed.
// RULE6 - reads store slave data from the internal address upward, writes source data from it.
// RULE7 - the configuring party keeps internal addresses inside the master port register range.
// RULE8 - the poll interval is in whole seconds and a command never repeats sooner than it; here a host trigger or a change runs it regardless of its timer.
// RULE9 - single coil and single register writes always act on exactly one point.
// RULE10 - count means bit points for codes 1, 2, 15 and registers for codes 3, 4, 16.
// RULE11 - received register pairs are reordered by swap code 0 to 3.
// RULE12 - node 1 to 255 is the destination station address of the request.
// RULE13 - node zero sends a broadcast, which is only used with writes.
// RULE14 - the functions served are 1, 2, 3, 4, 5, 6, 15 and 16.
// RULE15 - the slave address goes out as a zero-based offset into the range of the function.
// RULE16 - code 4 addresses input registers, code 3 holding registers; 1, 2, 5, 15 are bit addressed.
// RULE17 - swapping applies to holding register reads only.
module mbmcl_top #(
	parameter int unsigned SEC_CYCLES = mbmcl_pkg::SEC_CYCLES
) (
	input  wire logic                       ref_clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic [mbmcl_pkg::LENW-1:0] cmd_count_in,
	input  wire logic                       ld_valid_in,
	input  wire mbmcl_pkg::mbmcl_ld_kind_t  ld_kind_in,
	input  wire mbmcl_pkg::mbmcl_cmd_t      ld_rec_in,
	input  wire logic                       run_in,
	input  wire logic                       trig_in,
	input  wire logic [mbmcl_pkg::IDXW-1:0] trig_idx_in,
	input  wire logic                       chg_in,
	input  wire logic [mbmcl_pkg::IDXW-1:0] chg_idx_in,
	input  wire logic                       req_ready_in,
	input  wire logic                       done_in,
	input  wire logic                       rsp_valid_in,
	input  wire logic [31:0]                rsp_data_in,
	output logic                            req_valid_out,
	output mbmcl_pkg::mbmcl_req_t           req_out,
	output logic                            db_we_out,
	output logic [15:0]                     db_addr_out,
	output logic [31:0]                     db_data_out,
	output logic [mbmcl_pkg::LENW-1:0]      list_len_out,
	output logic                            list_loaded_out,
	output logic                            busy_out,
	output logic                            bad_cmd_out
);
	// ==========================================================
	// state and storage
	localparam int SECW = mbmcl_pkg::SECW;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SCAN  = 4'b0010,
		ST_ISSUE = 4'b0100,
		ST_WAIT  = 4'b1000
	} mbmcl_state_t;
	mbmcl_state_t                  state_q;
	mbmcl_pkg::mbmcl_cmd_t         tbl_q [mbmcl_pkg::NCMD];
	logic [16:0]                   tmr_q [mbmcl_pkg::NCMD];
	logic [mbmcl_pkg::NCMD-1:0]    chg_q;
	logic [mbmcl_pkg::LENW-1:0]    len_q;
	logic                          loading_q, loaded_q;
	logic [mbmcl_pkg::IDXW-1:0]    idx_q, cur_q;
	logic                          trig_pend_q, by_trig_q;
	logic [mbmcl_pkg::IDXW-1:0]    trig_idx_q;
	logic [mbmcl_pkg::SECW-1:0]    sec_cnt_q;
	logic                          tick_q, bad_q;
	mbmcl_pkg::mbmcl_req_t         req_q;
	logic [1:0]                    swap_q;
	logic [15:0]                   wptr_q;
	logic                          db_we_q;
	logic [15:0]                   db_addr_q;
	logic [31:0]                   db_data_q;
	// ==========================================================
	// selection of the entry under test
	wire logic                     use_trig = trig_pend_q;
	wire logic [mbmcl_pkg::IDXW-1:0] sel    = use_trig ? trig_idx_q : idx_q;
	wire mbmcl_pkg::mbmcl_cmd_t    rec      = tbl_q[sel];
	wire logic                     pass_end = !use_trig && ({1'b0, idx_q} >= len_q);
	// function decode
	wire logic f_rd  = (rec.func == mbmcl_pkg::FC_RD_COIL) || (rec.func == mbmcl_pkg::FC_RD_DISC) ||
	                   (rec.func == mbmcl_pkg::FC_RD_HOLD) || (rec.func == mbmcl_pkg::FC_RD_INPUT);
	wire logic f_wr  = (rec.func == mbmcl_pkg::FC_WR_COIL) || (rec.func == mbmcl_pkg::FC_WR_REG) ||
	                   (rec.func == mbmcl_pkg::FC_WR_COILS) || (rec.func == mbmcl_pkg::FC_WR_REGS);
	wire logic f_one = (rec.func == mbmcl_pkg::FC_WR_COIL) || (rec.func == mbmcl_pkg::FC_WR_REG);
	wire logic f_bit = (rec.func == mbmcl_pkg::FC_RD_COIL) || (rec.func == mbmcl_pkg::FC_RD_DISC) ||
	                   (rec.func == mbmcl_pkg::FC_WR_COIL) || (rec.func == mbmcl_pkg::FC_WR_COILS);
	wire logic bcast = (rec.node == mbmcl_pkg::NODE_BCAST);
	// only known functions, and no broadcast read
	wire logic legal = (f_rd || f_wr) && !(f_rd && bcast);                   // RULE14 RULE13
	// range selection per function
	wire mbmcl_pkg::mbmcl_space_t space =
		(rec.func == mbmcl_pkg::FC_RD_INPUT) ? mbmcl_pkg::MBMCL_SP_INPUT :      // RULE16
		(rec.func == mbmcl_pkg::FC_RD_DISC)  ? mbmcl_pkg::MBMCL_SP_DISC  :
		f_bit                                ? mbmcl_pkg::MBMCL_SP_COIL  :
		                                       mbmcl_pkg::MBMCL_SP_HOLD;
	// enable decisions; float-suppressed codes schedule alike
	wire logic en_poll = (rec.enable == mbmcl_pkg::EN_POLL) || (rec.enable == mbmcl_pkg::EN_POLL_NF);       // RULE5
	wire logic en_chg  = (rec.enable == mbmcl_pkg::EN_CHANGE) || (rec.enable == mbmcl_pkg::EN_CHANGE_NF);   // RULE5
	wire logic due     = (rec.poll_sec == 16'h0000) || (tmr_q[sel] == 17'h00000);                           // RULE3
	wire logic want    = use_trig ||                                                                        // RULE2
	                     (en_poll && due) ||                                                                // RULE3
	                     (en_chg && f_wr && chg_q[sel]);                                                    // RULE4
	// no decision while leaving the scan, so flags and timers are not spent without an issue
	wire logic scan_go = (state_q == ST_SCAN) && run_in && !loading_q && !pass_end;
	wire logic fire    = scan_go && want && legal;
	wire logic reject  = scan_go && ((want && !legal) || (en_chg && !f_wr && !use_trig));
	// request as sent
	wire mbmcl_pkg::mbmcl_req_t req_d = '{
		node:     rec.node,                                                     // RULE12
		bcast:    bcast,                                                        // RULE13
		func:     rec.func,
		space:    space,
		bits:     f_bit,                                                        // RULE10
		is_read:  f_rd,
		offset:   rec.dev_addr,                                                 // RULE15
		count:    f_one ? mbmcl_pkg::ONE_POINT : rec.count,                     // RULE9 RULE10
		int_addr: rec.int_addr                                                  // RULE6
	};
	// read data reorder, holding register reads only
	wire logic [1:0]  swap_d = (rec.func == mbmcl_pkg::FC_RD_HOLD) ? rec.swap : mbmcl_pkg::SW_NONE;  // RULE17
	wire logic [31:0] rsp_sw;
	mbmcl_swap u_swap (
		.data_in  (rsp_data_in),
		.code_in  (swap_q),
		.data_out (rsp_sw)
	);
	wire logic store = (state_q == ST_WAIT) && rsp_valid_in && req_q.is_read;
	// ==========================================================
	// list load from the start marker
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			loading_q <= 1'b0;
			loaded_q  <= 1'b0;
			len_q     <= '0;
			for (int i = 0; i < mbmcl_pkg::NCMD; i++) begin
				tbl_q[i] <= '0;
			end
		end else if (ld_valid_in && ld_kind_in == mbmcl_pkg::MBMCL_LD_START) begin
			loading_q <= 1'b1;                                                  // RULE1
			loaded_q  <= 1'b0;
			len_q     <= '0;
		end else if (ld_valid_in && ld_kind_in == mbmcl_pkg::MBMCL_LD_END) begin
			loading_q <= 1'b0;                                                  // RULE1
			loaded_q  <= loading_q | loaded_q;
		end else if (ld_valid_in && loading_q && ld_kind_in == mbmcl_pkg::MBMCL_LD_REC) begin
			if (len_q < cmd_count_in && len_q < 5'(mbmcl_pkg::NCMD)) begin
				tbl_q[len_q[mbmcl_pkg::IDXW-1:0]] <= ld_rec_in;
				len_q <= len_q + 5'h01;
			end else begin
				loading_q <= 1'b0;                                              // RULE1
				loaded_q  <= 1'b1;
			end
		end
	end
	// ==========================================================
	// one-second enable pulse
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sec_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else begin
			tick_q    <= (sec_cnt_q == SECW'(SEC_CYCLES - 1));
			sec_cnt_q <= (sec_cnt_q == SECW'(SEC_CYCLES - 1)) ? '0 : sec_cnt_q + 28'h0000001;
		end
	end
	// ==========================================================
	// interval timers, reloaded one second longer than the interval so a partial second never shortens the spacing
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < mbmcl_pkg::NCMD; i++) begin
				tmr_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < mbmcl_pkg::NCMD; i++) begin
				if (fire && sel == i && rec.poll_sec != 16'h0000) begin
					tmr_q[i] <= {1'b0, rec.poll_sec} + 17'h00001;               // RULE8
				end else if (tick_q && tmr_q[i] != 17'h00000) begin
					tmr_q[i] <= tmr_q[i] - 17'h00001;                           // RULE8
				end
			end
		end
	end
	// ==========================================================
	// change flags: a new change wins over the clear at issue
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			chg_q <= '0;
		end else begin
			for (int i = 0; i < mbmcl_pkg::NCMD; i++) begin
				if (chg_in && chg_idx_in == i) begin
					chg_q[i] <= 1'b1;                                           // RULE4
				end else if (fire && sel == i) begin
					chg_q[i] <= 1'b0;
				end
			end
		end
	end
	// ==========================================================
	// host trigger capture; a trigger while one is pending is dropped
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trig_pend_q <= 1'b0;
			trig_idx_q  <= '0;
		end else if (trig_in && !trig_pend_q) begin
			trig_pend_q <= 1'b1;                                                // RULE2
			trig_idx_q  <= trig_idx_in;
		end else if (scan_go && use_trig) begin
			trig_pend_q <= 1'b0;
		end
	end
	// ==========================================================
	// sequencer
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q   <= ST_IDLE;
			idx_q     <= '0;
			cur_q     <= '0;
			by_trig_q <= 1'b0;
			req_q     <= '0;
			swap_q    <= mbmcl_pkg::SW_NONE;
			bad_q     <= 1'b0;
		end else begin
			bad_q <= reject;
			case (state_q)
				ST_IDLE: begin
					idx_q <= '0;
					if (run_in && loaded_q && !loading_q) begin
						state_q <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (!run_in || loading_q) begin
						state_q <= ST_IDLE;
					end else if (pass_end) begin
						idx_q <= '0;                                            // RULE3
					end else if (fire) begin
						state_q   <= ST_ISSUE;
						cur_q     <= sel;
						by_trig_q <= use_trig;
						req_q     <= req_d;
						swap_q    <= swap_d;
					end else if (!use_trig) begin
						idx_q <= idx_q + 4'h1;                                  // RULE2
					end
				end
				ST_ISSUE: begin
					if (req_ready_in) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (done_in) begin
						state_q <= ST_SCAN;
						if (!by_trig_q) begin
							idx_q <= idx_q + 4'h1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	// ==========================================================
	// database write of reordered read data
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wptr_q    <= '0;
			db_we_q   <= 1'b0;
			db_addr_q <= '0;
			db_data_q <= '0;
		end else begin
			db_we_q <= store;
			if (fire) begin
				wptr_q <= rec.int_addr;                                         // RULE6
			end else if (store) begin
				wptr_q    <= wptr_q + mbmcl_pkg::PAIR_STRIDE;
				db_addr_q <= wptr_q;                                            // RULE6
				db_data_q <= rsp_sw;                                            // RULE11
			end
		end
	end
	// ==========================================================
	// outputs
	assign req_valid_out   = (state_q == ST_ISSUE);
	assign req_out         = req_q;
	assign db_we_out       = db_we_q;
	assign db_addr_out     = db_addr_q;
	assign db_data_out     = db_data_q;
	assign list_len_out    = len_q;
	assign list_loaded_out = loaded_q;
	assign busy_out        = (state_q == ST_ISSUE) || (state_q == ST_WAIT);
	assign bad_cmd_out     = bad_q;
	// ==========================================================
	// checks
	a_req_stable: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // request held stable while stalled
		req_valid_out && !req_ready_in |=> req_valid_out && $stable(req_out))
		else $error("request changed while stalled");
	a_single_point: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE9
		req_valid_out && (req_out.func == mbmcl_pkg::FC_WR_COIL || req_out.func == mbmcl_pkg::FC_WR_REG)
		|-> req_out.count == mbmcl_pkg::ONE_POINT)
		else $error("single write count not one");
	a_bcast_node: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE13
		req_valid_out |-> (req_out.bcast == (req_out.node == mbmcl_pkg::NODE_BCAST))
		&& !(req_out.bcast && req_out.is_read))
		else $error("broadcast flag wrong");
	a_space_map: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE16
		req_valid_out |-> (req_out.func == mbmcl_pkg::FC_RD_HOLD) ==
		(req_out.space == mbmcl_pkg::MBMCL_SP_HOLD && !req_out.bits && req_out.is_read))
		else $error("data range mismatch");
	a_swap_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE17
		store && req_q.func != mbmcl_pkg::FC_RD_HOLD |=> db_we_out && db_data_out == $past(rsp_data_in))
		else $error("swap on non holding read");
	a_skip_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE2
		fire && rec.enable == mbmcl_pkg::EN_OFF |-> use_trig)
		else $error("disabled command polled");
	a_interval_load: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE8
		fire && rec.poll_sec != 16'h0000 |=> tmr_q[cur_q] == {1'b0, $past(rec.poll_sec)} + 17'h00001)
		else $error("interval timer not reloaded");
	a_len_bound: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE1
		$rose(len_q != 5'h00) |-> $past(loading_q))
		else $error("record taken outside load");
	a_change_wr: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE4
		fire && en_chg && !use_trig |-> f_wr && chg_q[sel])
		else $error("change command issued without change");
endmodule
